/* File: dc_cmd_pkg.sv */
// constants for the device-side command decoder of the usb device controller
// assumes one 10 MHz clock, synchronous active-high reset, 16-bit data bus
// Notes on behaviour
// - codes a2..af read endpoint 2..15 error code, one word each.
// - code b0 plus the written key word aa37 unlocks all writable registers.
// - scratch register written by b2, read by b3, one word each.
// - code b4 returns current usb frame number in one word.
// - code b5 returns the fixed identification code in one word.
// - code c0 reads the interrupt register as two consecutive words.
// - n bytes take (n+1) div 2 word accesses on the 16-bit bus.
// - check-status reads a status copy and clears nothing.
// - 8-bit registers read in the low byte; upper byte is don't-care.
// - endpoint setup holds type, direction, size, buffering and enable.
// - usb bus reset disables every endpoint.
// - memory allocated only after all 16 endpoints configured in order.
// - allocation starts once endpoint 15 setup is written.
// - size or enable change invalidates all endpoint fifo contents.
// - codes 20..2f write the sixteen endpoint setups, one word.
// - codes 30..3f read back the sixteen endpoint setups, one word.
// - bit 7 set means fifo enabled with memory allocated.
// - bit 6 selects direction, 0 out 1 in, also dma direction.
// - bit 5 double buffering, bit 4 isochronous, bits 3..0 size code.
package dc_cmd_pkg;
    localparam int   NUM_EP          = 16;
    localparam int   LAST_EP         = 15;
    localparam [7:0] CMD_SETUP_WR    = 8'h20;
    localparam [7:0] CMD_SETUP_RD    = 8'h30;
    localparam [7:0] CMD_ERR_RD      = 8'ha0;
    localparam [7:0] CMD_UNLOCK      = 8'hb0;
    localparam [7:0] CMD_SCRATCH_WR  = 8'hb2;
    localparam [7:0] CMD_SCRATCH_RD  = 8'hb3;
    localparam [7:0] CMD_FRAME_RD    = 8'hb4;
    localparam [7:0] CMD_ID_RD       = 8'hb5;
    localparam [7:0] CMD_IRQ_RD      = 8'hc0;
    localparam [7:0] CMD_CHECK_RD    = 8'hd0;
    localparam [3:0] ERR_FIRST_EP    = 4'h2;
    localparam [7:0] SETUP_RESET     = 8'h00;
    localparam [15:0] SCRATCH_RESET  = 16'h0000;
    localparam [15:0] UNLOCK_KEY     = 16'haa37;
    // arbitrary identity value, not tied to any real part
    localparam [15:0] PART_IDENTITY  = 16'h5a01;
    localparam int   BIT_ENABLE      = 7;
    localparam int   BIT_DIR         = 6;
    localparam int   BIT_DOUBLE      = 5;
    localparam int   BIT_ISO         = 4;
    localparam int   SIZE_HI         = 3;
    localparam [7:0] ALLOC_MASK      = 8'h8f;
    localparam [4:0] ALLOC_CYCLES    = 5'h10;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WR    = 4'b0010,
        ST_RD    = 4'b0100,
        ST_RD2   = 4'b1000
    } phase_type;
endpackage

/* File: setup_sequencer.sv */
// tracks in-order endpoint setup writes and runs the fifo allocation pass
// assumes setup writes arrive as one-cycle strobes with the endpoint index
`timescale 1ns/1ns
module setup_sequencer (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       wr_stb,
    input  wire logic [3:0] wr_index,
    input  wire logic       layout_change,
    output logic            alloc_busy,
    output logic            alloc_done,
    output logic            fifo_invalidate
);
    logic [3:0] expect_q, expect_d;
    logic       busy_q, busy_d;
    logic       done_q, done_d;
    logic       inval_q, inval_d;
    logic [4:0] cnt_q, cnt_d;

    always_comb begin
        expect_d = expect_q;
        busy_d   = busy_q;
        done_d   = done_q;
        inval_d  = 1'b0;
        cnt_d    = cnt_q;
        if (wr_stb) begin
            // out-of-order write restarts the sequence
            expect_d = (wr_index == expect_q) ? expect_q + 4'h1 : 4'h0;
            if (wr_index == 4'h0) begin
                expect_d = 4'h1;
            end
            if (layout_change) begin
                inval_d = 1'b1;
                done_d  = 1'b0;
            end
            if (wr_index == expect_q && wr_index == 4'(dc_cmd_pkg::LAST_EP)) begin
                busy_d   = 1'b1;
                done_d   = 1'b0;
                cnt_d    = dc_cmd_pkg::ALLOC_CYCLES;
                expect_d = 4'h0;
                inval_d  = 1'b1;
            end
        end else if (busy_q) begin
            cnt_d = cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            expect_q <= 4'h0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            inval_q  <= 1'b0;
            cnt_q    <= 5'h0;
        end else if (ce) begin
            expect_q <= expect_d;
            busy_q   <= busy_d;
            done_q   <= done_d;
            inval_q  <= inval_d;
            cnt_q    <= cnt_d;
        end
    end

    assign alloc_busy      = busy_q;
    assign alloc_done      = done_q;
    assign fifo_invalidate = inval_q;
endmodule

/* File: usb_dev_endpoint_config_cmds.sv */
// command decoder for general and endpoint setup commands of the device side
// assumes cmd/data strobes come from same-clock bus logic; usb_bus_reset too
`timescale 1ns/1ns
module usb_dev_endpoint_config_cmds (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        cmd_wr,
    input  wire logic        data_wr,
    input  wire logic        data_rd,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic             cmd_active,
    input  wire logic        usb_bus_reset,
    input  wire logic [10:0] usb_frame_count,
    input  wire logic [31:0] device_irq_flags,
    input  wire logic [127:0] endpoint_error_code,
    input  wire logic [127:0] endpoint_status,
    output logic             locked,
    output logic [127:0]     endpoint_setup,
    output logic [15:0]      buffer_enabled,
    output logic [15:0]      endpoint_direction,
    output logic [15:0]      double_buffering,
    output logic [15:0]      isochronous_select,
    output logic [63:0]      buffer_size_code,
    output logic             alloc_busy,
    output logic             alloc_done,
    output logic             fifo_invalidate
);
    dc_cmd_pkg::phase_type phase_q, phase_d;
    logic [7:0]  code_q, code_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] scratch_q, scratch_d;
    logic        locked_q, locked_d;
    logic [7:0]  setup_q [dc_cmd_pkg::NUM_EP];
    logic [7:0]  setup_d [dc_cmd_pkg::NUM_EP];
    logic        seq_stb;
    logic        seq_change;
    logic [15:0] rd_word;

    function automatic logic [7:0] pick8(input logic [127:0] v, input logic [3:0] i);
        pick8 = v[{i, 3'b000} +: 8];
    endfunction

    function automatic logic is_group(input logic [7:0] c, input logic [7:0] base);
        is_group = (c[7:4] == base[7:4]);
    endfunction

    // word served by the first data phase of the latched read command
    always_comb begin
        rd_word = 16'h0000;
        if (is_group(code_q, dc_cmd_pkg::CMD_SETUP_RD)) begin
            rd_word = {8'h00, setup_q[code_q[3:0]]};
        end else if (is_group(code_q, dc_cmd_pkg::CMD_ERR_RD)) begin
            rd_word = {8'h00, pick8(endpoint_error_code, code_q[3:0])};
        end else if (is_group(code_q, dc_cmd_pkg::CMD_CHECK_RD)) begin
            // copy only; no clear is sent toward the status bits
            rd_word = {8'h00, pick8(endpoint_status, code_q[3:0])};
        end else if (code_q == dc_cmd_pkg::CMD_SCRATCH_RD) begin
            rd_word = scratch_q;
        end else if (code_q == dc_cmd_pkg::CMD_FRAME_RD) begin
            rd_word = {5'h00, usb_frame_count};
        end else if (code_q == dc_cmd_pkg::CMD_ID_RD) begin
            rd_word = dc_cmd_pkg::PART_IDENTITY;
        end else if (code_q == dc_cmd_pkg::CMD_IRQ_RD) begin
            rd_word = device_irq_flags[15:0];
        end
    end

    function automatic logic is_write(input logic [7:0] c);
        is_write = is_group(c, dc_cmd_pkg::CMD_SETUP_WR) || c == dc_cmd_pkg::CMD_UNLOCK
                   || c == dc_cmd_pkg::CMD_SCRATCH_WR;
    endfunction

    function automatic logic is_read(input logic [7:0] c);
        is_read = is_group(c, dc_cmd_pkg::CMD_SETUP_RD) || is_group(c, dc_cmd_pkg::CMD_CHECK_RD)
                  || (is_group(c, dc_cmd_pkg::CMD_ERR_RD) && c[3:0] >= dc_cmd_pkg::ERR_FIRST_EP)
                  || c == dc_cmd_pkg::CMD_SCRATCH_RD || c == dc_cmd_pkg::CMD_FRAME_RD
                  || c == dc_cmd_pkg::CMD_ID_RD || c == dc_cmd_pkg::CMD_IRQ_RD;
    endfunction

    always_comb begin
        phase_d    = phase_q;
        code_d     = code_q;
        rdata_d    = rdata_q;
        scratch_d  = scratch_q;
        locked_d   = locked_q;
        seq_stb    = 1'b0;
        seq_change = 1'b0;
        for (int i = 0; i < dc_cmd_pkg::NUM_EP; i++) begin
            setup_d[i] = setup_q[i];
        end
        if (cmd_wr) begin
            // a new code always aborts any unfinished data phase
            code_d = wdata[7:0];
            if (is_write(wdata[7:0])) begin
                phase_d = dc_cmd_pkg::ST_WR;
            end else if (is_read(wdata[7:0])) begin
                phase_d = dc_cmd_pkg::ST_RD;
            end else begin
                phase_d = dc_cmd_pkg::ST_IDLE;
            end
        end else begin
            case (phase_q)
                dc_cmd_pkg::ST_IDLE: begin
                    phase_d = dc_cmd_pkg::ST_IDLE;
                end
                dc_cmd_pkg::ST_WR: begin
                    if (data_wr) begin
                        phase_d = dc_cmd_pkg::ST_IDLE;
                        if (code_q == dc_cmd_pkg::CMD_UNLOCK) begin
                            if (wdata == dc_cmd_pkg::UNLOCK_KEY) begin
                                locked_d = 1'b0;
                            end
                        end else if (!locked_q) begin
                            if (code_q == dc_cmd_pkg::CMD_SCRATCH_WR) begin
                                scratch_d = wdata;
                            end else begin
                                setup_d[code_q[3:0]] = wdata[7:0];
                                seq_stb = 1'b1;
                                seq_change = (wdata[7:0] & dc_cmd_pkg::ALLOC_MASK)
                                             != (setup_q[code_q[3:0]] & dc_cmd_pkg::ALLOC_MASK);
                            end
                        end
                    end
                end
                dc_cmd_pkg::ST_RD: begin
                    rdata_d = rd_word;
                    if (data_rd) begin
                        if (code_q == dc_cmd_pkg::CMD_IRQ_RD) begin
                            phase_d = dc_cmd_pkg::ST_RD2;
                            rdata_d = device_irq_flags[31:16];
                        end else begin
                            phase_d = dc_cmd_pkg::ST_IDLE;
                        end
                    end
                end
                dc_cmd_pkg::ST_RD2: begin
                    if (data_rd) begin
                        phase_d = dc_cmd_pkg::ST_IDLE;
                    end
                end
                default: begin
                    phase_d = dc_cmd_pkg::ST_IDLE;
                end
            endcase
        end
        if (usb_bus_reset) begin
            for (int i = 0; i < dc_cmd_pkg::NUM_EP; i++) begin
                setup_d[i][dc_cmd_pkg::BIT_ENABLE] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q   <= dc_cmd_pkg::ST_IDLE;
            code_q    <= 8'h00;
            rdata_q   <= 16'h0000;
            scratch_q <= dc_cmd_pkg::SCRATCH_RESET;
            locked_q  <= 1'b0;
            for (int i = 0; i < dc_cmd_pkg::NUM_EP; i++) begin
                setup_q[i] <= dc_cmd_pkg::SETUP_RESET;
            end
        end else if (ce) begin
            phase_q   <= phase_d;
            code_q    <= code_d;
            rdata_q   <= rdata_d;
            scratch_q <= scratch_d;
            locked_q  <= locked_d;
            for (int i = 0; i < dc_cmd_pkg::NUM_EP; i++) begin
                setup_q[i] <= setup_d[i];
            end
        end
    end

    setup_sequencer u_seq (
        .mclk            (mclk),
        .rst             (rst),
        .ce              (ce),
        .wr_stb          (seq_stb),
        .wr_index        (code_q[3:0]),
        .layout_change   (seq_change),
        .alloc_busy      (alloc_busy),
        .alloc_done      (alloc_done),
        .fifo_invalidate (fifo_invalidate)
    );

    // per-endpoint field fan-out for the fifo and dma logic
    always_comb begin
        for (int i = 0; i < dc_cmd_pkg::NUM_EP; i++) begin
            endpoint_setup[i*8 +: 8]   = setup_q[i];
            buffer_enabled[i]          = setup_q[i][dc_cmd_pkg::BIT_ENABLE];
            endpoint_direction[i]      = setup_q[i][dc_cmd_pkg::BIT_DIR];
            double_buffering[i]        = setup_q[i][dc_cmd_pkg::BIT_DOUBLE];
            isochronous_select[i]      = setup_q[i][dc_cmd_pkg::BIT_ISO];
            buffer_size_code[i*4 +: 4] = setup_q[i][dc_cmd_pkg::SIZE_HI:0];
        end
    end

    assign rdata      = rdata_q;
    assign cmd_active = (phase_q != dc_cmd_pkg::ST_IDLE);
    assign locked     = locked_q;
endmodule

/* File: usb_dev_endpoint_config_cmds_checker.sv */
// assertions for the endpoint setup command decoder
// bound to the decoder top module, sees its ports only
`timescale 1ns/1ns
module usb_dev_endpoint_config_cmds_checker (
    input wire logic         mclk,
    input wire logic         rst,
    input wire logic         ce,
    input wire logic         cmd_wr,
    input wire logic         data_wr,
    input wire logic         data_rd,
    input wire logic [15:0]  wdata,
    input wire logic [15:0]  rdata,
    input wire logic         cmd_active,
    input wire logic         usb_bus_reset,
    input wire logic [10:0]  usb_frame_count,
    input wire logic [31:0]  device_irq_flags,
    input wire logic [127:0] endpoint_setup,
    input wire logic [15:0]  buffer_enabled,
    input wire logic         alloc_busy,
    input wire logic         alloc_done,
    input wire logic         fifo_invalidate
);
    function automatic logic [15:0] bits(input logic [127:0] s, input int b);
        for (int i = 0; i < 16; i++) begin
            bits[i] = s[i * 8 + b];
        end
    endfunction
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_setup_wr;
        ce && cmd_wr && wdata[7:4] == 4'h2 ##1 ce && data_wr && !cmd_wr && !usb_bus_reset;
    endsequence
    // rdata loads one edge after the code is taken, so a quiet cycle must follow
    sequence s_irq_cmd;
        ce && cmd_wr && wdata[7:0] == dc_cmd_pkg::CMD_IRQ_RD ##1 ce && !cmd_wr;
    endsequence
    AST_EN_FIELD: assert property (buffer_enabled == bits(endpoint_setup, 7))
        else $error("enable field wrong");
    AST_BUS_RESET: assert property (ce && usb_bus_reset |=> buffer_enabled == 16'h0000)
        else $error("bus reset left an endpoint on");
    AST_SETUP_WR: assert property (s_setup_wr |=> !cmd_active && endpoint_setup[$past(wdata[3:0], 2) * 8 +: 8] == $past(wdata[7:0]))
        else $error("setup write lost");
    AST_SETUP_RD: assert property (ce && cmd_wr && wdata[7:4] == 4'h3 ##1 ce && !cmd_wr && !usb_bus_reset
        |-> cmd_active ##1 rdata[7:0] == endpoint_setup[$past(wdata[3:0], 2) * 8 +: 8])
        else $error("setup read wrong");
    AST_ID: assert property (ce && cmd_wr && wdata[7:0] == dc_cmd_pkg::CMD_ID_RD ##1 ce && !cmd_wr
        |=> rdata == dc_cmd_pkg::PART_IDENTITY)
        else $error("identity wrong");
    AST_FRAME: assert property (ce && cmd_wr && wdata[7:0] == dc_cmd_pkg::CMD_FRAME_RD ##1 ce && !cmd_wr
        |=> rdata[10:0] == $past(usb_frame_count))
        else $error("frame number wrong");
    AST_IRQ_LO: assert property (s_irq_cmd |=> rdata == $past(device_irq_flags[15:0]))
        else $error("irq low word wrong");
    AST_IRQ_HI: assert property (s_irq_cmd ##1 ce && data_rd && !cmd_wr |=> rdata == $past(device_irq_flags[31:16]))
        else $error("irq high word wrong");
    AST_ALLOC: assert property ($rose(alloc_busy) |-> ##15 alloc_busy ##1 !alloc_busy && alloc_done)
        else $error("allocation length wrong");
    AST_INVAL: assert property ($rose(alloc_busy) |-> $past(fifo_invalidate) or ##[0:1] fifo_invalidate)
        else $error("allocation without invalidate");
endmodule
bind usb_dev_endpoint_config_cmds usb_dev_endpoint_config_cmds_checker chk (.mclk(mclk), .rst(rst), .ce(ce),
    .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .cmd_active(cmd_active),
    .usb_bus_reset(usb_bus_reset), .usb_frame_count(usb_frame_count), .device_irq_flags(device_irq_flags),
    .endpoint_setup(endpoint_setup), .buffer_enabled(buffer_enabled), .alloc_busy(alloc_busy),
    .alloc_done(alloc_done), .fifo_invalidate(fifo_invalidate));

/* File: bus_processor_model.sv */
// processor model: command code, then data words, on the falling edge
// bench calls op(); never validates out or clears in buffers, no fifo data
`timescale 1ns/1ns
module bus_processor_model (
    input  wire logic  mclk,
    output logic       cmd_wr,
    output logic       data_wr,
    output logic       data_rd,
    output logic [15:0] wdata
);
    initial begin
        cmd_wr = 1'b0;
        data_wr = 1'b0;
        data_rd = 1'b0;
        wdata = 16'h5a5a;
    end
    task automatic op(input logic [7:0] c, input logic [15:0] w, input int nwr, input int nrd);
        @(negedge mclk);
        cmd_wr = 1'b1;
        wdata = {8'h00, c};
        @(negedge mclk);
        cmd_wr = 1'b0;
        if (nwr > 0) begin
            data_wr = 1'b1;
            wdata = w;
            @(negedge mclk);
            data_wr = 1'b0;
            // bus released: stale value would hide a missed latch
            wdata = ~w;
        end else begin
            wdata = ~wdata;
        end
        if (nrd > 0) begin
            @(negedge mclk);
            data_rd = 1'b1;
            repeat (nrd) @(negedge mclk);
            data_rd = 1'b0;
        end
    endtask
endmodule

/* File: usb_dev_endpoint_config_cmds_bench.sv */
// self-checking bench for the endpoint setup command decoder
// inputs change on the falling edge; the processor model makes the strobes
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module usb_dev_endpoint_config_cmds_bench;
    localparam logic [7:0] CTRL_SETUP = 8'h80;
    logic         mclk = 1'b0;
    logic         rst, ce, usb_bus_reset, cmd_wr, data_wr, data_rd, cmd_active, locked, busy, done, inval;
    logic [10:0]  usb_frame_count;
    logic [15:0]  wdata, rdata, w, en, dir, dbl, iso;
    logic [31:0]  device_irq_flags, note;
    logic [63:0]  size;
    logic [127:0] endpoint_error_code, endpoint_status, endpoint_setup;
    logic [7:0]   s [16];
    logic [7:0]   f;
    logic [31:0]  notes [$];
    int           seed = 6150;
    int           failures = 0;
    int           comparisons = 0;
    int           pulses = 0;
    int           k;
    always #50 mclk = ~mclk;
    usb_dev_endpoint_config_cmds dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd_wr(cmd_wr), .data_wr(data_wr),
        .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .cmd_active(cmd_active), .usb_bus_reset(usb_bus_reset),
        .usb_frame_count(usb_frame_count), .device_irq_flags(device_irq_flags), .locked(locked),
        .endpoint_error_code(endpoint_error_code), .endpoint_status(endpoint_status), .endpoint_setup(endpoint_setup),
        .buffer_enabled(en), .endpoint_direction(dir), .double_buffering(dbl), .isochronous_select(iso),
        .buffer_size_code(size), .alloc_busy(busy), .alloc_done(done), .fifo_invalidate(inval));
    bus_processor_model proc (.mclk(mclk), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata));
    always @(posedge mclk) begin
        if (inval === 1'b1) begin
            pulses++;
        end
        if (data_rd === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            `CHK(rdata & note[31:16], note[15:0])
        end
    end
    task automatic rd(input logic [7:0] c, input logic [15:0] m, e0, e1, input int n);
        notes.push_back({m, e0});
        if (n == 2) begin
            notes.push_back({m, e1});
        end
        proc.op(c, 16'h0000, 0, n);
    endtask
    task automatic end_of_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        usb_bus_reset = 1'b0;
        usb_frame_count = 11'($random(seed));
        device_irq_flags = $random(seed);
        endpoint_error_code = {$random(seed), $random(seed), $random(seed), $random(seed)};
        endpoint_status = {$random(seed), $random(seed), $random(seed), $random(seed)};
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        `CHK({endpoint_setup, busy, done, locked}, 131'h0)
        for (k = 0; k < 16; k++) begin
            rd(8'h30 + 8'(k), 16'h00ff, 16'h0000, 16'h0000, 1);
        end
        proc.op(dc_cmd_pkg::CMD_UNLOCK, dc_cmd_pkg::UNLOCK_KEY, 1, 0);
        `CHK(locked, 1'b0)
        w = $random(seed);
        proc.op(dc_cmd_pkg::CMD_SCRATCH_WR, w, 1, 0);
        rd(dc_cmd_pkg::CMD_SCRATCH_RD, 16'hffff, w, w, 1);
        rd(dc_cmd_pkg::CMD_FRAME_RD, 16'h07ff, {5'h00, usb_frame_count}, w, 1);
        rd(dc_cmd_pkg::CMD_ID_RD, 16'hffff, dc_cmd_pkg::PART_IDENTITY, w, 1);
        rd(dc_cmd_pkg::CMD_IRQ_RD, 16'hffff, device_irq_flags[15:0], device_irq_flags[31:16], 2);
        for (k = 2; k < 16; k++) begin
            rd(8'ha0 + 8'(k), 16'h00ff, {8'h00, endpoint_error_code[k*8+:8]}, w, 1);
        end
        // status copy read twice: a clearing read would show on the second
        for (k = 0; k < 32; k++) begin
            rd(8'hd0 + 8'(k % 16), 16'h00ff, {8'h00, endpoint_status[(k % 16)*8+:8]}, w, 1);
        end
        // first pass skips endpoint 2, so no allocation may follow
        for (int p = 0; p < 2; p++) begin
            for (k = 0; k < 16; k++) begin
                s[k] = k < 2 ? CTRL_SETUP | {1'b0, k[0], 6'h00} : 8'($random(seed)) | 8'h80;
                if (p == 1 || k != 2) begin
                    proc.op(8'h20 + 8'(k), {8'h00, s[k]}, 1, 0);
                end
            end
            for (k = 0; k < 40 && done !== 1'b1; k++) begin
                @(negedge mclk);
            end
            `CHK(done, p == 1)
        end
        // a missing allocation is already counted; skip straight to the report
        if (done === 1'b1) begin
            for (k = 0; k < 16; k++) begin
                f = {en[k], dir[k], dbl[k], iso[k], size[k*4+:4]};
                `CHK(f, s[k])
                rd(8'h30 + 8'(k), 16'h00ff, {8'h00, s[k]}, w, 1);
            end
            usb_bus_reset = 1'b1;
            @(negedge mclk);
            usb_bus_reset = 1'b0;
            repeat (3) @(negedge mclk);
            `CHK(en, 16'h0000)
            `CHK(endpoint_setup[47:40], s[5] & 8'h7f)
            pulses = 0;
            proc.op(8'h25, {8'h00, (s[5] & 8'h7f) ^ 8'h20}, 1, 0);
            repeat (3) @(negedge mclk);
            `CHK(pulses, 0)
            proc.op(8'h25, {8'h00, (s[5] & 8'h7f) ^ 8'h21}, 1, 0);
            repeat (3) @(negedge mclk);
            `CHK(pulses > 0, 1'b1)
        end
        `CHK(notes.size(), 0)
        end_of_test();
    end
endmodule
